//--- src/ccs_pkg.sv
// ccs_pkg: register map, field positions and timing of the clock switcher
package ccs_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int RST_PROC_MIN_NS = 11000;
   localparam int RST_PROC_CYC = (RST_PROC_MIN_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int MAIN_SETTLE_NS = 204800;
   localparam int SUB_SETTLE_NS = 102400;
   localparam int INT_SETTLE_NS = 3200;
   localparam int SWITCH_NS = 400;
   localparam int SWITCH_CYC = (SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   // register byte offsets
   localparam logic [4:0] OFS_OSC_MODE = 5'h00;
   localparam logic [4:0] OFS_MAIN_OSC = 5'h04;
   localparam logic [4:0] OFS_MAIN_CLK = 5'h08;
   localparam logic [4:0] OFS_INT_OSC = 5'h0C;
   localparam logic [4:0] OFS_PROC_CLK = 5'h10;
   localparam logic [4:0] OFS_SETTLE = 5'h14;
   // field positions
   localparam int B_EXT_SEL = 7;
   localparam int B_MAIN_PIN = 6;
   localparam int B_SUB_PIN = 4;
   localparam int B_MAIN_HALT = 7;
   localparam int B_HS_SRC = 2;
   localparam int B_MAIN_SEL = 0;
   localparam int B_INT_STABLE = 7;
   localparam int B_INT_HALT = 0;
   localparam int B_CPU_SUB = 4;
   localparam int B_ON_SUB = 5;
   localparam int B_MAIN_STAT = 1;
   // reset values
   localparam logic RV_MAIN_HALT = 1'b1;
   localparam logic RV_ZERO = 1'b0;
   // clock sources
   typedef enum logic [2:0] {
      CCS_SRC_INT = 3'b001,
      CCS_SRC_HS = 3'b010,
      CCS_SRC_SUB = 3'b100
   } ccs_src_t;
   // cpu clock states
   typedef enum logic [8:0] {
      CCS_ST_RST = 9'h001,
      CCS_ST_INT = 9'h002,
      CCS_ST_HS = 9'h004,
      CCS_ST_SUB = 9'h008,
      CCS_ST_HALT_INT = 9'h010,
      CCS_ST_HALT_HS = 9'h020,
      CCS_ST_HALT_SUB = 9'h040,
      CCS_ST_STOP_INT = 9'h080,
      CCS_ST_STOP_HS = 9'h100
   } ccs_state_t;
endpackage

//--- src/ccs_settle.sv
// ccs_settle: saturating oscillation settle counter
`timescale 1ns/1ps
`default_nettype none
module ccs_settle #(
   parameter int CNT_W = 16,
   parameter logic [CNT_W-1:0] LIMIT = 16'h0800
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic run,
   // status
   output logic [CNT_W-1:0] count,
   output logic settled
);
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // restarts from zero whenever the oscillator stops
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (!run)
         cnt_nxt = '0;
      else if (cnt_r != LIMIT)
         cnt_nxt = cnt_r + 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         cnt_r <= '0;
      else
         cnt_r <= cnt_nxt;
   end

   assign count = cnt_r;
   assign settled = (cnt_r == LIMIT);
endmodule
`default_nettype wire

//--- src/ccs_top.sv
// ccs_top: cpu clock source state machine with avalon register slave
//
// Function
// - after reset the cpu runs on the internal oscillator with no writes
// - in two-threshold mode, wait for supply, then reset processing, then run
// - high speed source select accepts only one change per reset
// - halt gives a distinct halt state for each of the three clock states
// - osc mode register: input select bit 7, main pins 6, sub pins 4
// - main osc control register: halt at bit 7
// - main clock mode register: source select bit 2, main select bit 0
// - internal osc register: stable flag bit 7, halt bit 0
// - processor clock register: subsystem select at bit 4
// - two read-only status bits report which clock feeds the cpu
`timescale 1ns/1ps
`default_nettype none
module ccs_top
   import ccs_pkg::*;
#(
   parameter logic [ccs_pkg::CNT_W-1:0] MAIN_SETTLE_CYC =
      16'(ccs_pkg::MAIN_SETTLE_NS / ccs_pkg::CLK_PERIOD_NS),
   parameter logic [ccs_pkg::CNT_W-1:0] SUB_SETTLE_CYC =
      16'(ccs_pkg::SUB_SETTLE_NS / ccs_pkg::CLK_PERIOD_NS),
   parameter logic [ccs_pkg::CNT_W-1:0] INT_SETTLE_CYC =
      16'(ccs_pkg::INT_SETTLE_NS / ccs_pkg::CLK_PERIOD_NS)
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // power and cpu events
   input wire logic power_on_clear_mode,
   input wire logic supply_above_upper,
   input wire logic halt_exec,
   input wire logic stop_exec,
   input wire logic wake_event,
   // clock outputs
   output ccs_pkg::ccs_src_t cpu_clk_src,
   output logic cpu_clk_run,
   output ccs_pkg::ccs_state_t cpu_clk_state,
   output logic main_osc_run,
   output logic sub_osc_run,
   output logic int_osc_run
);
   import ccs_pkg::*;

   ccs_state_t st_r, st_nxt;
   ccs_src_t cur_r, cur_nxt;
   logic [CNT_W-1:0] tmr_r, tmr_nxt;
   logic ext_sel_r, main_pin_r, sub_pin_r, main_halt_r, hs_src_r, main_sel_r;
   logic int_halt_r, cpu_sub_r, hs_lock_r, ack_r, main_stat_r;
   logic ext_sel_nxt, main_pin_nxt, sub_pin_nxt, main_halt_nxt, hs_src_nxt;
   logic main_sel_nxt, int_halt_nxt, cpu_sub_nxt, hs_lock_nxt, ack_nxt;
   logic main_stat_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wr_go, rd_go, stopped, main_ok, sub_ok, int_ok;
   logic main_settled, sub_settled, int_settled;
   logic [CNT_W-1:0] main_cnt;
   ccs_src_t req_src;

   function automatic logic src_ok(ccs_src_t s, logic i, logic m, logic b);
      src_ok = (s == CCS_SRC_INT) ? i : ((s == CCS_SRC_HS) ? m : b);
   endfunction

   // bus: one wait cycle, write lands at the second edge, read data is registered at the first
   assign waitrequest = (read || write) && !ack_r;
   assign wr_go = write && ack_r;
   assign rd_go = read && !ack_r;
   assign readdata = rdata_r;

   // oscillators
   assign stopped = (st_r == CCS_ST_STOP_INT) || (st_r == CCS_ST_STOP_HS);
   assign main_osc_run = main_pin_r && !main_halt_r && !stopped;
   assign int_osc_run = !int_halt_r && !stopped;
   assign sub_osc_run = sub_pin_r;

   ccs_settle #(.CNT_W(CNT_W), .LIMIT(MAIN_SETTLE_CYC)) u_main (
      .ref_clk(ref_clk), .rst(rst), .run(main_osc_run),
      .count(main_cnt), .settled(main_settled));
   ccs_settle #(.CNT_W(CNT_W), .LIMIT(SUB_SETTLE_CYC)) u_sub (
      .ref_clk(ref_clk), .rst(rst), .run(sub_osc_run),
      .count(), .settled(sub_settled));
   ccs_settle #(.CNT_W(CNT_W), .LIMIT(INT_SETTLE_CYC)) u_int (
      .ref_clk(ref_clk), .rst(rst), .run(int_osc_run),
      .count(), .settled(int_settled));

   // external input needs no settling; crystal does
   assign main_ok = main_osc_run && hs_src_r && (ext_sel_r || main_settled);
   assign int_ok = int_osc_run;
   assign sub_ok = sub_osc_run && sub_settled;

   // subsystem select dominates the main select
   assign req_src = cpu_sub_r ? CCS_SRC_SUB :
      ((main_sel_r && hs_src_r) ? CCS_SRC_HS : CCS_SRC_INT);

   // registers
   always_comb
   begin
      ext_sel_nxt = ext_sel_r;
      main_pin_nxt = main_pin_r;
      sub_pin_nxt = sub_pin_r;
      main_halt_nxt = main_halt_r;
      hs_src_nxt = hs_src_r;
      hs_lock_nxt = hs_lock_r;
      main_sel_nxt = main_sel_r;
      int_halt_nxt = int_halt_r;
      cpu_sub_nxt = cpu_sub_r;
      ack_nxt = (read || write) && !ack_r;
      rdata_nxt = rdata_r;
      if (wr_go && byteenable[0])
      begin
         unique case (address)
            OFS_OSC_MODE:
            begin
               ext_sel_nxt = writedata[B_EXT_SEL];
               main_pin_nxt = writedata[B_MAIN_PIN];
               sub_pin_nxt = writedata[B_SUB_PIN];
            end
            OFS_MAIN_OSC: main_halt_nxt = writedata[B_MAIN_HALT];
            OFS_MAIN_CLK:
            begin
               main_sel_nxt = writedata[B_MAIN_SEL];
               if (!hs_lock_r && writedata[B_HS_SRC] != hs_src_r)
               begin
                  hs_src_nxt = writedata[B_HS_SRC];
                  hs_lock_nxt = 1'b1;
               end
            end
            OFS_INT_OSC: int_halt_nxt = writedata[B_INT_HALT];
            OFS_PROC_CLK: cpu_sub_nxt = writedata[B_CPU_SUB];
            default: ;
         endcase
      end
      if (rd_go)
      begin
         rdata_nxt = '0;
         unique case (address)
            OFS_OSC_MODE:
            begin
               rdata_nxt[B_EXT_SEL] = ext_sel_r;
               rdata_nxt[B_MAIN_PIN] = main_pin_r;
               rdata_nxt[B_SUB_PIN] = sub_pin_r;
            end
            OFS_MAIN_OSC: rdata_nxt[B_MAIN_HALT] = main_halt_r;
            OFS_MAIN_CLK:
            begin
               rdata_nxt[B_HS_SRC] = hs_src_r;
               rdata_nxt[B_MAIN_SEL] = main_sel_r;
               rdata_nxt[B_MAIN_STAT] = main_stat_r;
            end
            OFS_INT_OSC:
            begin
               rdata_nxt[B_INT_STABLE] = int_osc_run && int_settled;
               rdata_nxt[B_INT_HALT] = int_halt_r;
            end
            OFS_PROC_CLK:
            begin
               rdata_nxt[B_CPU_SUB] = cpu_sub_r;
               rdata_nxt[B_ON_SUB] = (cur_r == CCS_SRC_SUB);
            end
            // settle counter for software to poll
            OFS_SETTLE: rdata_nxt[CNT_W-1:0] = main_cnt;
            default: ;
         endcase
      end
   end

   // state machine and clock switch
   always_comb
   begin
      st_nxt = st_r;
      cur_nxt = cur_r;
      tmr_nxt = tmr_r;
      main_stat_nxt = main_stat_r;
      unique case (st_r)
         // in two-threshold mode hold until supply passes the upper threshold, then count reset processing
         CCS_ST_RST:
         begin
            if (power_on_clear_mode && !supply_above_upper)
               tmr_nxt = '0;
            else if (tmr_r == CNT_W'(RST_PROC_CYC - 1))
            begin
               st_nxt = CCS_ST_INT;
               tmr_nxt = '0;
            end
            else
               tmr_nxt = tmr_r + 1'b1;
         end
         CCS_ST_INT, CCS_ST_HS, CCS_ST_SUB:
         begin
            if (halt_exec)
               st_nxt = (st_r == CCS_ST_INT) ? CCS_ST_HALT_INT :
                  ((st_r == CCS_ST_HS) ? CCS_ST_HALT_HS : CCS_ST_HALT_SUB);
            // stop not offered on subsystem clock
            else if (stop_exec && st_r != CCS_ST_SUB)
               st_nxt = (st_r == CCS_ST_INT) ? CCS_ST_STOP_INT :
                  CCS_ST_STOP_HS;
            // stay on old clock until new one valid
            else if (req_src != cur_r &&
               src_ok(req_src, int_ok, main_ok, sub_ok))
            begin
               if (tmr_r == CNT_W'(SWITCH_CYC - 1))
               begin
                  cur_nxt = req_src;
                  tmr_nxt = '0;
                  if (req_src != CCS_SRC_SUB)
                     main_stat_nxt = (req_src == CCS_SRC_HS);
                  st_nxt = (req_src == CCS_SRC_INT) ? CCS_ST_INT :
                     ((req_src == CCS_SRC_HS) ? CCS_ST_HS : CCS_ST_SUB);
               end
               else
                  tmr_nxt = tmr_r + 1'b1;
            end
            else
               tmr_nxt = '0;
         end
         CCS_ST_HALT_INT, CCS_ST_HALT_HS, CCS_ST_HALT_SUB:
            if (wake_event)
               st_nxt = (st_r == CCS_ST_HALT_INT) ? CCS_ST_INT :
                  ((st_r == CCS_ST_HALT_HS) ? CCS_ST_HS : CCS_ST_SUB);
         // oscillators restart on wake, so a wait is not modelled here
         CCS_ST_STOP_INT, CCS_ST_STOP_HS:
            if (wake_event)
               st_nxt = (st_r == CCS_ST_STOP_INT) ? CCS_ST_INT : CCS_ST_HS;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_r <= CCS_ST_RST;
         cur_r <= CCS_SRC_INT;
         tmr_r <= '0;
         main_stat_r <= RV_ZERO;
         ext_sel_r <= RV_ZERO;
         main_pin_r <= RV_ZERO;
         sub_pin_r <= RV_ZERO;
         main_halt_r <= RV_MAIN_HALT;
         hs_src_r <= RV_ZERO;
         hs_lock_r <= RV_ZERO;
         main_sel_r <= RV_ZERO;
         int_halt_r <= RV_ZERO;
         cpu_sub_r <= RV_ZERO;
         ack_r <= RV_ZERO;
         rdata_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
         cur_r <= cur_nxt;
         tmr_r <= tmr_nxt;
         main_stat_r <= main_stat_nxt;
         ext_sel_r <= ext_sel_nxt;
         main_pin_r <= main_pin_nxt;
         sub_pin_r <= sub_pin_nxt;
         main_halt_r <= main_halt_nxt;
         hs_src_r <= hs_src_nxt;
         hs_lock_r <= hs_lock_nxt;
         main_sel_r <= main_sel_nxt;
         int_halt_r <= int_halt_nxt;
         cpu_sub_r <= cpu_sub_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign cpu_clk_src = cur_r;
   assign cpu_clk_state = st_r;
   assign cpu_clk_run = (st_r == CCS_ST_INT) || (st_r == CCS_ST_HS) ||
      (st_r == CCS_ST_SUB);

   // slack for the release edge and the registered state
   localparam int RST_HI = RST_PROC_CYC + 3;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   AST_RESET_INT: assert property (
      $fell(rst) && !power_on_clear_mode |-> ##[1:RST_HI]
      (st_r == CCS_ST_INT && cur_r == CCS_SRC_INT))
      else $error("no internal clock state after reset");
   AST_POC_HOLD: assert property (
      st_r == CCS_ST_RST && power_on_clear_mode && !supply_above_upper
      |=> st_r == CCS_ST_RST)
      else $error("left reset state below upper threshold");
   AST_HS_ONCE: assert property (
      hs_lock_r |=> hs_src_r == $past(hs_src_r))
      else $error("source select changed twice");
   AST_HALT: assert property (
      st_r == CCS_ST_SUB && halt_exec |=> st_r == CCS_ST_HALT_SUB)
      else $error("halt from subsystem missed");
   AST_NO_STOP_SUB: assert property (
      st_r == CCS_ST_SUB && stop_exec |=> !stopped)
      else $error("stop entered from subsystem clock");
   AST_OSC_BITS: assert property (
      write && ack_r && byteenable[0] && address == OFS_OSC_MODE
      |=> ext_sel_r == $past(writedata[B_EXT_SEL]) &&
      sub_pin_r == $past(writedata[B_SUB_PIN]))
      else $error("osc mode bits not stored");
   AST_MOC_BIT: assert property (
      write && ack_r && byteenable[0] && address == OFS_MAIN_OSC
      |=> main_halt_r == $past(writedata[B_MAIN_HALT]))
      else $error("main osc halt not stored");
   AST_SUB_STATUS: assert property (
      $rose(cur_r == CCS_SRC_SUB) |-> $past(cpu_sub_r))
      else $error("subsystem clock without select");
   AST_GLITCH: assert property (
      $changed(cur_r) && !$past(rst) |->
      $past(src_ok(req_src, int_ok, main_ok, sub_ok)) &&
      cur_r == $past(req_src) && $past(tmr_r) == CNT_W'(SWITCH_CYC - 1))
      else $error("switched to invalid clock");
endmodule
`default_nettype wire

//--- tb/tb.sv
// tb: self-checking bench for the cpu clock source switcher
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ccs_pkg::*;
   logic ref_clk, rst, read, write, power_on_clear_mode, supply_above_upper;
   logic halt_exec, stop_exec, wake_event, waitrequest;
   logic cpu_clk_run, main_osc_run, sub_osc_run, int_osc_run;
   logic [4:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, q;
   ccs_src_t cpu_clk_src;
   ccs_state_t cpu_clk_state;
   int fail_count = 0;
   int n_tests = 0;

   // short settle counts keep the run brief
   ccs_top #(.MAIN_SETTLE_CYC(16'h0008), .SUB_SETTLE_CYC(16'h0008),
      .INT_SETTLE_CYC(16'h0004)) uut (.ref_clk(ref_clk), .rst(rst),
      .address(address), .read(read), .write(write),
      .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .power_on_clear_mode(power_on_clear_mode),
      .supply_above_upper(supply_above_upper), .halt_exec(halt_exec),
      .stop_exec(stop_exec), .wake_event(wake_event),
      .cpu_clk_src(cpu_clk_src), .cpu_clk_run(cpu_clk_run),
      .cpu_clk_state(cpu_clk_state), .main_osc_run(main_osc_run),
      .sub_osc_run(sub_osc_run), .int_osc_run(int_osc_run));

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask

   // one avalon access; waitrequest and read data taken at the rising edge
   task bus(input logic [4:0] a, input logic w, input logic [3:0] be,
      input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      address <= a;
      write <= w;
      read <= !w;
      byteenable <= be;
      writedata <= d;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 50)
         chk("waitrequest", 32'h0, 32'h1);
   endtask

   task wr(input logic [4:0] a, input logic [31:0] d);
      bus(a, 1'b1, 4'hF, d);
   endtask

   task rd(input logic [4:0] a, input logic [31:0] e);
      bus(a, 1'b0, 4'hF, 32'h0);
      chk("readdata", e, q);
   endtask

   task wait_st(input ccs_state_t s, input int max);
      int n;
      n = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
      end while (cpu_clk_state !== s && n < max);
      chk("state", 32'(s), 32'(cpu_clk_state));
   endtask

   // events are one-cycle pulses: halt, stop, wake
   task ev(input logic [2:0] v, input ccs_state_t s);
      @(posedge ref_clk);
      {halt_exec, stop_exec, wake_event} <= v;
      @(posedge ref_clk);
      {halt_exec, stop_exec, wake_event} <= 3'h0;
      @(negedge ref_clk);
      chk("event state", 32'(s), 32'(cpu_clk_state));
   endtask

   task do_reset;
      rst <= 1'b1;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
   endtask

   initial
   begin
      {read, write, halt_exec, stop_exec, wake_event} = 5'h0;
      {power_on_clear_mode, supply_above_upper} = 2'h0;
      address = 5'h00;
      byteenable = 4'h0;
      writedata = 32'h0;
      do_reset();
      repeat (100) @(negedge ref_clk);
      chk("reset state", 32'(CCS_ST_RST), 32'(cpu_clk_state));
      wait_st(CCS_ST_INT, 30);
      chk("src", 32'(CCS_SRC_INT), 32'(cpu_clk_src));
      chk("cpu run", 32'h1, 32'(cpu_clk_run));
      chk("int osc", 32'h1, 32'(int_osc_run));
      chk("main osc", 32'h0, 32'(main_osc_run));
      rd(OFS_OSC_MODE, 32'h00);
      rd(OFS_MAIN_OSC, 32'h80);
      rd(OFS_MAIN_CLK, 32'h00);
      rd(OFS_PROC_CLK, 32'h00);
      rd(OFS_INT_OSC, 32'h80);
      rd(5'h18, 32'h00);
      ev(3'h4, CCS_ST_HALT_INT);
      chk("cpu run", 32'h0, 32'(cpu_clk_run));
      ev(3'h1, CCS_ST_INT);
      ev(3'h2, CCS_ST_STOP_INT);
      ev(3'h1, CCS_ST_INT);
      bus(OFS_MAIN_OSC, 1'b1, 4'h0, 32'h0);
      rd(OFS_MAIN_OSC, 32'h80);
      // external input path, no settle check needed
      wr(OFS_OSC_MODE, 32'hC0);
      wr(OFS_MAIN_OSC, 32'h00);
      wr(OFS_MAIN_CLK, 32'h04);
      wr(OFS_MAIN_CLK, 32'h05);
      repeat (3) @(negedge ref_clk);
      chk("src held", 32'(CCS_SRC_INT), 32'(cpu_clk_src));
      wait_st(CCS_ST_HS, 40);
      chk("src", 32'(CCS_SRC_HS), 32'(cpu_clk_src));
      rd(OFS_MAIN_CLK, 32'h07);
      wr(OFS_MAIN_CLK, 32'h01);
      rd(OFS_MAIN_CLK, 32'h07);
      ev(3'h4, CCS_ST_HALT_HS);
      ev(3'h1, CCS_ST_HS);
      ev(3'h2, CCS_ST_STOP_HS);
      ev(3'h1, CCS_ST_HS);
      // subsystem clock
      wr(OFS_OSC_MODE, 32'hD0);
      wr(OFS_PROC_CLK, 32'h10);
      wait_st(CCS_ST_SUB, 40);
      chk("src", 32'(CCS_SRC_SUB), 32'(cpu_clk_src));
      chk("sub osc", 32'h1, 32'(sub_osc_run));
      rd(OFS_PROC_CLK, 32'h30);
      ev(3'h4, CCS_ST_HALT_SUB);
      ev(3'h1, CCS_ST_SUB);
      ev(3'h2, CCS_ST_SUB);
      wr(OFS_PROC_CLK, 32'h00);
      wait_st(CCS_ST_HS, 40);
      wr(OFS_MAIN_CLK, 32'h04);
      wait_st(CCS_ST_INT, 40);
      rd(OFS_MAIN_CLK, 32'h04);
      // crystal path after a fresh oscillator start
      wr(OFS_MAIN_OSC, 32'h80);
      wr(OFS_OSC_MODE, 32'h50);
      wr(OFS_MAIN_OSC, 32'h00);
      repeat (20) @(posedge ref_clk);
      rd(OFS_SETTLE, 32'h0008);
      wr(OFS_MAIN_CLK, 32'h05);
      wait_st(CCS_ST_HS, 40);
      // internal osc halted only once the cpu runs elsewhere
      rd(OFS_MAIN_CLK, 32'h07);
      wr(OFS_INT_OSC, 32'h01);
      rd(OFS_INT_OSC, 32'h01);
      chk("int osc", 32'h0, 32'(int_osc_run));
      // two-threshold supply mode
      @(posedge ref_clk);
      power_on_clear_mode <= 1'b1;
      do_reset();
      repeat (150) @(negedge ref_clk);
      chk("no supply", 32'(CCS_ST_RST), 32'(cpu_clk_state));
      @(posedge ref_clk);
      supply_above_upper <= 1'b1;
      repeat (100) @(negedge ref_clk);
      chk("processing", 32'(CCS_ST_RST), 32'(cpu_clk_state));
      wait_st(CCS_ST_INT, 30);
      // sub back to internal with main select left set, source select 0
      wr(OFS_OSC_MODE, 32'h10);
      wr(OFS_PROC_CLK, 32'h10);
      wait_st(CCS_ST_SUB, 40);
      wr(OFS_MAIN_CLK, 32'h01);
      wr(OFS_PROC_CLK, 32'h00);
      wait_st(CCS_ST_INT, 40);
      rd(OFS_MAIN_CLK, 32'h01);
      stop_test();
   end

   // hang guard: the sequence needs well under 3000 cycles
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      stop_test();
   end
endmodule
`default_nettype wire
